// ---- src/ipsf_top.sv ----
// IP service framer: sample reports, header check and serial relay
`timescale 1ns/10ps
`default_nettype none
`include "ipsf_map.svh"
module ipsf_top
  import ipsf_pkg::*;
#(
  parameter int NCH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             srst,
  input  wire logic [7:0]       paddr,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             sampleReq,
  input  wire logic [15:0]      digSample,
  input  wire logic [16*NCH-1:0] anaSample,
  input  wire logic             serRxValid,
  input  wire logic [7:0]       serRxData,
  input  wire logic             serRxLast,
  output logic                  serRxReady,
  output logic                  serTxValid,
  output logic      [7:0]       serTxData,
  input  wire logic             serTxReady,
  input  wire logic             netRxValid,
  input  wire logic [7:0]       netRxData,
  input  wire logic             netRxLast,
  input  wire logic [15:0]      netRxPort,
  output logic                  netRxReady,
  output logic                  netTxValid,
  output logic      [7:0]       netTxData,
  output logic                  netTxLast,
  input  wire logic             netTxReady,
  output logic                  netTxUdp,
  output logic                  netTxConn,
  output logic      [31:0]      netTxAddr,
  output logic      [15:0]      netTxDstPort,
  output logic      [15:0]      netTxSrcPort,
  output logic                  tcpOpenReq,
  input  wire logic             tcpOpened,
  input  wire logic             tcpClosed,
  input  wire logic             peerConnReq,
  output logic                  peerAccept,
  output logic                  upgInstall,
  output logic                  ackReq
);
  localparam int CW = $clog2(NCH);
  localparam logic [15:0] CHK  = `IPSF_CHECK;
  localparam logic [15:0] NUM2 = `IPSF_NUM2;
  localparam logic [15:0] APP  = `IPSF_APP_PORT;

  //==========================================================
  // Register file
  logic [31:0]    dstAddr;
  logic [15:0]    dstPort;
  logic [15:0]    srcPort;
  logic           tcpMode;
  logic           apiMode;
  logic [15:0]    digMask;
  logic [NCH-1:0] anaMask;
  logic [7:0]     rejectCnt;
  logic [7:0]     installCnt;
  logic           connected;
  logic           mapped;
  logic [31:0]    rdMux;
  ipsf_rep_type   repState;
  wire apbWr    = psel & penable & pwrite;
  wire apbSetup = psel & ~penable;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always_comb begin
    mapped = 1'b1;
    rdMux  = 32'h0;
    case (paddr)
      `IPSF_REG_DADDR: rdMux = dstAddr;
      `IPSF_REG_DPORT: rdMux = {16'h0, dstPort};
      `IPSF_REG_SPORT: rdMux = {16'h0, srcPort};
      `IPSF_REG_CTRL:  rdMux = {30'h0, apiMode, tcpMode};
      `IPSF_REG_DMASK: rdMux = {16'h0, digMask};
      `IPSF_REG_AMASK: rdMux = {{(32-NCH){1'b0}}, anaMask};
      `IPSF_REG_STAT:  rdMux = {8'h0, installCnt, rejectCnt, 5'h0, repState != REP_IDLE, tcpOpenReq, connected};
      default:         mapped = 1'b0;
    endcase
  end

  // Read data latched in setup so the access phase answers at once
  always_ff @(posedge sys_clk) begin
    if (srst) prdata <= 32'h0;
    else if (apbSetup & ~pwrite) prdata <= rdMux;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dstAddr <= `IPSF_RST_DADDR;
      dstPort <= `IPSF_RST_PORT;
      srcPort <= `IPSF_RST_PORT;
      tcpMode <= 1'b0;
      apiMode <= 1'b0;
      digMask <= 16'h0000;
      anaMask <= '0;
    end else if (apbWr) begin
      case (paddr)
        `IPSF_REG_DADDR: dstAddr <= pwdata;
        `IPSF_REG_DPORT: if (pwdata[15:0] != APP) dstPort <= pwdata[15:0];
        `IPSF_REG_SPORT: if (pwdata[15:0] != APP) srcPort <= pwdata[15:0];
        `IPSF_REG_CTRL: begin
          tcpMode <= pwdata[`IPSF_CTRL_TCP];
          apiMode <= pwdata[`IPSF_CTRL_API];
        end
        `IPSF_REG_DMASK: digMask <= pwdata[15:0];
        `IPSF_REG_AMASK: anaMask <= pwdata[NCH-1:0];
        default: ;
      endcase
    end
  end

  //==========================================================
  // Sample report builder
  logic [3:0]     idx;
  logic           half;
  logic [CW-1:0]  ch;
  logic [15:0]    snapD;
  logic [15:0]    snapDm;
  logic [NCH-1:0] snapAm;
  logic [15:0]    snapA [NCH];
  logic           repValid;
  logic           repLast;
  logic [7:0]     repByte;
  logic           srcTake;
  ipsf_owner_type owner;
  wire repStart = (repState == REP_IDLE) & sampleReq;
  wire higher   = |(snapAm >> (32'(ch) + 1));
  wire repTake  = (owner == OWN_REP) & srcTake;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_snap
      always_ff @(posedge sys_clk) begin
        if (srst) snapA[g] <= 16'h0000;
        else if (repStart) snapA[g] <= anaSample[16*g +: 16];
      end
    end
  endgenerate

  always_comb begin
    repValid = 1'b1;
    repLast  = 1'b0;
    repByte  = 8'h00;
    case (repState)
      REP_HDR: begin
        case (idx)
          4'd0:    repByte = CHK[15:8];
          4'd1:    repByte = CHK[7:0];
          4'd2:    repByte = NUM2[15:8];
          4'd3:    repByte = NUM2[7:0];
          4'd6:    repByte = `IPSF_CMD_SAMPLE;
          4'd8:    repByte = `IPSF_NUM_SETS;
          4'd9:    repByte = snapDm[15:8];
          4'd10:   repByte = snapDm[7:0];
          4'd11:   repByte = 8'(snapAm);
          default: repByte = 8'h00;
        endcase
        repLast = (idx == `IPSF_OFS_HDREND) && (snapDm == 16'h0) && (snapAm == '0);
      end
      REP_DIG: begin
        repByte = half ? snapD[7:0] : snapD[15:8];
        repLast = half && (snapAm == '0);
      end
      REP_ANA: begin
        // Disabled channels below the highest enabled one cost one idle cycle each
        repValid = snapAm[ch];
        repByte  = half ? snapA[ch][7:0] : snapA[ch][15:8];
        repLast  = half && !higher;
      end
      default: repValid = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      repState <= REP_IDLE;
      idx      <= 4'd0;
      half     <= 1'b0;
      ch       <= '0;
      snapD    <= 16'h0000;
      snapDm   <= 16'h0000;
      snapAm   <= '0;
    end else begin
      case (repState)
        REP_IDLE: begin
          // A request while a report is in flight is dropped
          if (sampleReq) begin
            repState <= REP_HDR;
            idx      <= 4'd0;
            half     <= 1'b0;
            ch       <= '0;
            snapD    <= digSample;
            snapDm   <= digMask;
            snapAm   <= anaMask;
          end
        end
        REP_HDR: begin
          if (repTake) begin
            idx <= idx + 4'd1;
            if (idx == `IPSF_OFS_HDREND) begin
              if (snapDm != 16'h0) repState <= REP_DIG;
              else if (snapAm != '0) repState <= REP_ANA;
              else repState <= REP_IDLE;
            end
          end
        end
        REP_DIG: begin
          if (repTake) begin
            half <= ~half;
            if (half) repState <= (snapAm != '0) ? REP_ANA : REP_IDLE;
          end
        end
        REP_ANA: begin
          if (!snapAm[ch]) begin
            ch <= ch + 1'b1;
          end else if (repTake) begin
            half <= ~half;
            if (half && !higher) repState <= REP_IDLE;
            else if (half) ch <= ch + 1'b1;
          end
        end
        default: repState <= REP_IDLE;
      endcase
    end
  end

  //==========================================================
  // Transmit arbitration and output stage
  logic srcValid;
  logic srcLast;
  logic [7:0] srcByte;
  wire bcast    = (dstAddr[7:0] == `IPSF_BCAST_LSB);
  wire relUdp   = ~tcpMode | bcast;
  wire needConn = ~relUdp & ~apiMode;
  wire routeOk  = ~needConn | connected;
  wire stageFree = ~netTxValid | netTxReady;
  wire grantRel  = (owner == OWN_NONE) & ~netTxValid & (repState == REP_IDLE) & serRxValid & routeOk;

  always_comb begin
    srcValid = 1'b0;
    srcLast  = 1'b0;
    srcByte  = 8'h00;
    case (owner)
      OWN_REP: begin
        srcValid = repValid;
        srcLast  = repLast;
        srcByte  = repByte;
      end
      OWN_REL: begin
        srcValid = serRxValid;
        srcLast  = serRxLast;
        srcByte  = serRxData;
      end
      default: ;
    endcase
  end
  assign srcTake    = srcValid & stageFree;
  assign serRxReady = (owner == OWN_REL) & stageFree;

  // Grant only on an empty stage so frame details never change under a byte
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      owner        <= OWN_NONE;
      netTxUdp     <= 1'b0;
      netTxConn    <= 1'b0;
      netTxAddr    <= 32'h0;
      netTxDstPort <= 16'h0;
      netTxSrcPort <= 16'h0;
    end else if (owner == OWN_NONE) begin
      if (~netTxValid & (repState != REP_IDLE)) begin
        owner        <= OWN_REP;
        netTxUdp     <= 1'b1;
        netTxConn    <= 1'b0;
        netTxAddr    <= dstAddr;
        netTxDstPort <= dstPort;
        netTxSrcPort <= APP;
      end else if (grantRel) begin
        owner        <= OWN_REL;
        netTxUdp     <= relUdp;
        netTxConn    <= needConn;
        netTxAddr    <= dstAddr;
        netTxDstPort <= dstPort;
        netTxSrcPort <= srcPort;
      end
    end else if (srcTake & srcLast) begin
      owner <= OWN_NONE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      netTxValid <= 1'b0;
      netTxData  <= 8'h00;
      netTxLast  <= 1'b0;
    end else if (stageFree) begin
      netTxValid <= srcValid;
      netTxData  <= srcByte;
      netTxLast  <= srcLast;
    end
  end

  //==========================================================
  // Receive routing
  ipsf_stream_if appIf ();
  logic frameOk;
  logic frameBad;
  wire toApp   = (netRxPort == APP);
  wire toSer   = ~toApp & (netRxPort == srcPort);
  wire serFree = ~serTxValid | serTxReady;

  assign netRxReady  = toSer ? serFree : (toApp ? appIf.ready : 1'b1);
  assign appIf.valid = netRxValid & toApp;
  assign appIf.data  = netRxData;
  assign appIf.last  = netRxLast;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      serTxValid <= 1'b0;
      serTxData  <= 8'h00;
    end else if (serFree) begin
      serTxValid <= netRxValid & toSer;
      serTxData  <= netRxData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rejectCnt  <= 8'h00;
      installCnt <= 8'h00;
    end else begin
      if (frameBad) rejectCnt <= rejectCnt + 8'h01;
      if (upgInstall) installCnt <= installCnt + 8'h01;
    end
  end

  ipsf_hdr_check u_check (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .rx         (appIf.snk),
    .frameOk    (frameOk),
    .frameBad   (frameBad),
    .upgInstall (upgInstall),
    .ackReq     (ackReq)
  );

  ipsf_conn u_conn (
    .sys_clk     (sys_clk),
    .srst        (srst),
    .wantOpen    (serRxValid & needConn & ~connected),
    .peerConnReq (peerConnReq & ~apiMode),
    .tcpOpened   (tcpOpened),
    .tcpClosed   (tcpClosed),
    .tcpOpenReq  (tcpOpenReq),
    .peerAccept  (peerAccept),
    .connected   (connected)
  );

  //==========================================================
  // Checks
  logic [7:0] frmIdx;
  logic       repFrame;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      frmIdx   <= 8'h00;
      repFrame <= 1'b0;
    end else begin
      if (owner == OWN_NONE && ~netTxValid) repFrame <= (repState != REP_IDLE);
      if (netTxValid & netTxReady) frmIdx <= netTxLast ? 8'h00 : (frmIdx == 8'hFF ? frmIdx : frmIdx + 8'h01);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence s_repByte(int n);
    repFrame && netTxValid && frmIdx == 8'(n);
  endsequence
  sequence s_portWr;
    apbWr && (paddr == `IPSF_REG_SPORT) && (pwdata[15:0] == APP);
  endsequence

  chk_rep_route: assert property (repFrame && netTxValid |-> netTxUdp && netTxSrcPort == APP)
    else $error("report not sent by UDP from service port");
  chk_rep_magic: assert property (s_repByte(0) or s_repByte(1) |-> netTxData == 8'h42)
    else $error("report check word wrong");
  chk_rep_resvd: assert property (s_repByte(4) or s_repByte(5) or s_repByte(7) |-> netTxData == 8'h00)
    else $error("report reserved byte nonzero");
  chk_rep_cmd: assert property (s_repByte(6) |-> netTxData == 8'h04)
    else $error("report command byte wrong");
  chk_rep_count: assert property (s_repByte(8) |-> netTxData == 8'h01)
    else $error("report set count wrong");
  chk_rep_dmask: assert property (s_repByte(9) |-> netTxData == snapDm[15:8])
    else $error("digital mask high byte wrong");
  chk_rep_amask: assert property (s_repByte(11) |-> netTxData == 8'(snapAm))
    else $error("analog mask byte wrong");
  chk_relay_pass: assert property (serRxValid && serRxReady |=> netTxValid && netTxData == $past(serRxData))
    else $error("relay byte altered");
  chk_port_guard: assert property (s_portWr |=> srcPort == $past(srcPort))
    else $error("service port taken as relay port");
  chk_relay_meta: assert property (grantRel |=> netTxUdp == (!$past(tcpMode) || $past(bcast))
    && netTxSrcPort == $past(srcPort))
    else $error("relay frame details wrong");
  chk_open_tcp: assert property (tcpOpenReq && !tcpClosed && !tcpOpened |=> tcpOpenReq && !connected)
    else $error("open request dropped");
endmodule : ipsf_top
`default_nettype wire

// ---- pkg/ipsf_map.svh ----
// Offsets, field positions, reset values and frame constants of the IP service framer
`ifndef IPSF_MAP_SVH
`define IPSF_MAP_SVH
`define IPSF_APP_PORT   16'h0BEE
`define IPSF_CHECK      16'h4242
`define IPSF_NUM2       16'h0000
`define IPSF_CMD_SAMPLE 8'h04
`define IPSF_CMD_TXDATA 8'h00
`define IPSF_OPT_ACK    8'h02
`define IPSF_UPG_INST   8'h06
`define IPSF_NUM_SETS   8'h01
`define IPSF_BCAST_LSB  8'hFF
`define IPSF_OFS_CMD    5'd6
`define IPSF_OFS_OPT    5'd7
`define IPSF_OFS_UPG    5'd8
`define IPSF_OFS_HDREND 4'd11
`define IPSF_REG_DADDR  8'h00
`define IPSF_REG_DPORT  8'h04
`define IPSF_REG_SPORT  8'h08
`define IPSF_REG_CTRL   8'h0C
`define IPSF_REG_DMASK  8'h10
`define IPSF_REG_AMASK  8'h14
`define IPSF_REG_STAT   8'h18
`define IPSF_CTRL_TCP   0
`define IPSF_CTRL_API   1
`define IPSF_RST_DADDR  32'hFFFFFFFF
`define IPSF_RST_PORT   16'h1000
`endif

// ---- pkg/ipsf_pkg.sv ----
// Types shared by the IP service framer modules
package ipsf_pkg;
  typedef enum logic [1:0] {OWN_NONE, OWN_REP, OWN_REL} ipsf_owner_type;
  typedef enum logic [1:0] {REP_IDLE, REP_HDR, REP_DIG, REP_ANA} ipsf_rep_type;
  typedef enum logic [1:0] {CONN_IDLE, CONN_OPENING, CONN_OPEN} ipsf_conn_type;
endpackage : ipsf_pkg

// ---- pkg/ipsf_stream_if.sv ----
// Byte stream carrier between framer modules
`timescale 1ns/10ps
`default_nettype none
interface ipsf_stream_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  logic       last;
  modport src (output valid, output data, output last, input ready);
  modport snk (input valid, input data, input last, output ready);
endinterface : ipsf_stream_if
`default_nettype wire

// ---- src/ipsf_hdr_check.sv ----
// Application header check on frames arriving at the service port
`timescale 1ns/10ps
`default_nettype none
`include "ipsf_map.svh"
module ipsf_hdr_check
  import ipsf_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic srst,
  ipsf_stream_if.snk rx,
  output logic      frameOk,
  output logic      frameBad,
  output logic      upgInstall,
  output logic      ackReq
);
  localparam logic [15:0] CHK = `IPSF_CHECK;
  logic [4:0]  idx;
  logic [31:0] words;
  logic [7:0]  cmd, opt, upg;
  logic        headOk;
  wire fire = rx.valid & rx.ready;
  assign rx.ready = 1'b1;
  // Short frames never reach byte 4 and so fail
  assign headOk = (idx > 5'd3) && ((words[31:16] ^ words[15:0]) == CHK);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      idx   <= 5'd0;
      words <= 32'h0;
      cmd   <= 8'h00;
      opt   <= 8'h00;
      upg   <= 8'h00;
    end else if (fire) begin
      idx <= rx.last ? 5'd0 : (idx == 5'h1F ? idx : idx + 5'd1);
      if (idx < 5'd4) begin
        words <= {words[23:0], rx.data};
      end
      if (idx == `IPSF_OFS_CMD) cmd <= rx.data;
      if (idx == `IPSF_OFS_OPT) opt <= rx.data;
      if (idx == `IPSF_OFS_UPG) upg <= rx.data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      frameOk    <= 1'b0;
      frameBad   <= 1'b0;
      upgInstall <= 1'b0;
      ackReq     <= 1'b0;
    end else begin
      frameOk    <= fire & rx.last & headOk;
      frameBad   <= fire & rx.last & ~headOk;
      upgInstall <= fire & rx.last & headOk & (idx > `IPSF_OFS_UPG) & (cmd == `IPSF_CMD_TXDATA)
                    & (opt == `IPSF_OPT_ACK) & (upg == `IPSF_UPG_INST);
      ackReq     <= fire & rx.last & headOk & (opt == `IPSF_OPT_ACK);
    end
  end

  chk_bad_no_install: assert property (@(posedge sys_clk) disable iff (srst)
    frameBad |-> !upgInstall && !ackReq && !frameOk)
    else $error("rejected frame raised an upgrade or ack");
endmodule : ipsf_hdr_check
`default_nettype wire

// ---- src/ipsf_conn.sv ----
// Single TCP connection keeper for transparent relay
`timescale 1ns/10ps
`default_nettype none
module ipsf_conn
  import ipsf_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic wantOpen,
  input  wire logic peerConnReq,
  input  wire logic tcpOpened,
  input  wire logic tcpClosed,
  output logic      tcpOpenReq,
  output logic      peerAccept,
  output logic      connected
);
  ipsf_conn_type state;
  assign tcpOpenReq = (state == CONN_OPENING);
  assign connected  = (state == CONN_OPEN);
  // Only an idle keeper accepts a client, so one connection at most
  assign peerAccept = (state == CONN_IDLE) & peerConnReq;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state <= CONN_IDLE;
    end else begin
      case (state)
        CONN_IDLE: begin
          if (peerConnReq) state <= CONN_OPEN;
          else if (wantOpen) state <= CONN_OPENING;
        end
        CONN_OPENING: begin
          if (tcpClosed) state <= CONN_IDLE;
          else if (tcpOpened) state <= CONN_OPEN;
        end
        CONN_OPEN: begin
          if (tcpClosed) state <= CONN_IDLE;
        end
        default: state <= CONN_IDLE;
      endcase
    end
  end

  chk_one_conn: assert property (@(posedge sys_clk) disable iff (srst)
    peerAccept |-> !connected ##1 connected)
    else $error("client accepted while a connection existed");
endmodule : ipsf_conn
`default_nettype wire

// ---- sim/ipsf_net_peer.sv ----
// Network stack model facing the framer's outgoing stream and TCP handshake
`timescale 1ns/10ps
`default_nettype none
module ipsf_net_peer (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic tcpOpenReq,
  output logic      netTxReady,
  output logic      tcpOpened
);
  // ====================
  // Back-pressure and open
  logic [2:0] beat;
  logic [2:0] openWait;
  always_ff @(posedge sys_clk) begin
    beat     <= srst ? 3'h0 : beat + 3'h1;
    openWait <= (srst || !tcpOpenReq) ? 3'h0 : openWait + 3'h1;
  end
  // One stall in eight so the sender must hold its byte
  assign netTxReady = beat != 3'h7;
  // Slow stack: open completes after four cycles of request
  assign tcpOpened  = openWait == 3'h4;
endmodule : ipsf_net_peer
`default_nettype wire

// ---- sim/ipsf_top_bench.sv ----
// Self-checking bench of the IP service framer
`timescale 1ns/10ps
`default_nettype none
`include "ipsf_map.svh"
module ipsf_top_bench;
  localparam int          NCH   = 8;
  localparam logic [31:0] DA    = 32'h0A000005;
  localparam logic [31:0] RV[4] = '{32'hFFFFFFFF, 32'h00001000, 32'h00001000, 32'h00000000};
  localparam logic [31:0] WV[3] = '{DA, 32'h00002222, 32'h00003333};
  logic sys_clk, srst, psel, penable, pwrite, pready, pslverr, sampleReq, serRxValid, serRxLast, serRxReady;
  logic serTxValid, serTxReady, netRxValid, netRxLast, netRxReady, netTxValid, netTxLast, netTxReady, netTxUdp;
  logic netTxConn, tcpOpenReq, tcpOpened, tcpClosed, peerConnReq, peerAccept, upgInstall, ackReq, err, txConn;
  logic [7:0]        paddr, serRxData, serTxData, netRxData, netTxData;
  logic [15:0]       digSample, netRxPort, netTxDstPort, netTxSrcPort;
  logic [31:0]       pwdata, prdata, rd, netTxAddr;
  logic [16*NCH-1:0] anaSample;
  logic [64:0]       txMeta;
  logic [8:0]        txQ[$];
  logic [7:0]        serQ[$];
  int                n_mismatch, check_count, cyc, nInst, nAck, nOpen;

  ipsf_top #(.NCH(NCH)) ipsf_top_i (.sys_clk, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .sampleReq, .digSample, .anaSample, .serRxValid, .serRxData, .serRxLast, .serRxReady, .serTxValid,
    .serTxData, .serTxReady, .netRxValid, .netRxData, .netRxLast, .netRxPort, .netRxReady, .netTxValid, .netTxData,
    .netTxLast, .netTxReady, .netTxUdp, .netTxConn, .netTxAddr, .netTxDstPort, .netTxSrcPort, .tcpOpenReq,
    .tcpOpened, .tcpClosed, .peerConnReq, .peerAccept, .upgInstall, .ackReq);
  ipsf_net_peer ipsf_net_peer_i (.sys_clk, .srst, .tcpOpenReq, .netTxReady, .tcpOpened);

  // ====================
  // Clock, monitors, timeout
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc   <= cyc + 1;
    nInst <= nInst + int'(upgInstall === 1'b1);
    nAck  <= nAck + int'(ackReq === 1'b1);
    nOpen <= nOpen + int'(tcpOpenReq === 1'b1 && tcpOpened === 1'b1);
    if (netTxValid === 1'b1 && netTxReady) begin
      txQ.push_back({netTxLast, netTxData});
      txMeta <= {netTxUdp, netTxAddr, netTxDstPort, netTxSrcPort};
      txConn <= netTxConn;
    end
    if (serTxValid === 1'b1 && serTxReady)
      serQ.push_back(serTxData);
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop;
    end
  end

  // ====================
  // Shared tasks
  task automatic chk(input logic [64:0] got, input logic [64:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk);
    while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic send(input logic net, input logic [7:0] b[$]);
    foreach (b[i]) begin
      serRxValid <= !net;
      netRxValid <= net;
      serRxData  <= b[i];
      netRxData  <= b[i];
      serRxLast  <= (i == b.size() - 1);
      netRxLast  <= (i == b.size() - 1);
      do @(posedge sys_clk);
      while ((net ? netRxReady : serRxReady) !== 1'b1);
    end
    serRxValid <= 1'b0;
    netRxValid <= 1'b0;
    @(posedge sys_clk);
  endtask : send

  task automatic wait_last;
    repeat (300) begin
      @(negedge sys_clk);
      if (txQ.size() > 0 && txQ[$][8] === 1'b1)
        break;
    end
    @(posedge sys_clk);
  endtask : wait_last

  task automatic one(input logic [31:0] ctl, input logic [31:0] a, input logic [7:0] b, input logic u);
    apb(1'b1, `IPSF_REG_CTRL, ctl);
    apb(1'b1, `IPSF_REG_DADDR, a);
    txQ.delete();
    send(1'b0, '{b});
    wait_last;
    chk(txQ[0], {1'b1, b});
    chk(txMeta[64], u);
  endtask : one

  // ====================
  // Scenarios
  task automatic t_regs;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, RV[i]);
    end
    apb(1'b0, 8'h1C, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    for (int i = 0; i < 3; i++)
      apb(1'b1, 8'(4 * i), WV[i]);
    apb(1'b1, `IPSF_REG_DPORT, 32'h00000BEE);
    apb(1'b1, `IPSF_REG_SPORT, 32'h00000BEE);
    apb(1'b0, `IPSF_REG_DPORT, 32'h0);
    chk(rd, WV[1]);
    apb(1'b0, `IPSF_REG_SPORT, 32'h0);
    chk(rd, WV[2]);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_report(input logic [15:0] dm, input logic [7:0] am);
    logic [7:0] e[$];
    apb(1'b1, `IPSF_REG_DMASK, {16'h0, dm});
    apb(1'b1, `IPSF_REG_AMASK, {24'h0, am});
    e = '{8'h42, 8'h42, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h01, dm[15:8], dm[7:0], am};
    if (dm != 16'h0)
      e = {e, digSample[15:8], digSample[7:0]};
    for (int g = 0; g < NCH; g++)
      if (am[g])
        e = {e, anaSample[16*g+8+:8], anaSample[16*g+:8]};
    txQ.delete();
    sampleReq <= 1'b1;
    @(posedge sys_clk);
    sampleReq <= 1'b0;
    wait_last;
    chk(txQ.size(), e.size());
    foreach (e[i])
      chk(txQ[i], {i == e.size() - 1, e[i]});
    chk(txMeta, {1'b1, DA, WV[1][15:0], 16'h0BEE});
    $display("t_report done");
  endtask : t_report

  task automatic t_relay;
    txQ.delete();
    send(1'b0, '{8'h11, 8'h22, 8'h33});
    wait_last;
    chk({txQ[0], txQ[1], txQ[2]}, {9'h011, 9'h022, 9'h133});
    chk(txMeta, {1'b1, DA, WV[1][15:0], WV[2][15:0]});
    netRxPort <= WV[2][15:0];
    send(1'b1, '{8'h55, 8'h66});
    netRxPort <= 16'h4444;
    send(1'b1, '{8'h77});
    repeat (5) @(posedge sys_clk);
    chk({serQ.size(), serQ[0], serQ[1]}, {32'd2, 8'h55, 8'h66});
    $display("t_relay done");
  endtask : t_relay

  task automatic t_hdr;
    netRxPort <= 16'h0BEE;
    send(1'b1, '{8'h42, 8'h42, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                 8'h00, 8'h00});
    send(1'b1, '{8'h42, 8'h42, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h02, 8'h06});
    repeat (4) @(posedge sys_clk);
    chk({nInst, nAck}, {32'd1, 32'd1});
    apb(1'b0, `IPSF_REG_STAT, 32'h0);
    chk(rd[23:8], 16'h0101);
    $display("t_hdr done");
  endtask : t_hdr

  task automatic t_tcp;
    one(32'h1, DA, 8'h5A, 1'b0);
    chk(txConn, 1'b1);
    one(32'h1, DA, 8'h5D, 1'b0);
    chk(txConn, 1'b1);
    peerConnReq <= 1'b1;
    @(negedge sys_clk);
    chk(peerAccept, 1'b0);
    @(posedge sys_clk);
    peerConnReq <= 1'b0;
    tcpClosed   <= 1'b1;
    @(posedge sys_clk);
    tcpClosed <= 1'b0;
    // Client opens the link; serial data must ride it without a new open
    peerConnReq <= 1'b1;
    @(negedge sys_clk);
    chk(peerAccept, 1'b1);
    @(posedge sys_clk);
    peerConnReq <= 1'b0;
    one(32'h1, DA, 8'h5E, 1'b0);
    chk(txConn, 1'b1);
    one(32'h1, 32'h0A0000FF, 8'h5B, 1'b1);
    one(32'h3, 32'h0A0000FF, 8'h5C, 1'b1);
    chk(nOpen, 1);
    $display("t_tcp done");
  endtask : t_tcp

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  initial begin
    {psel, penable, pwrite, sampleReq, serRxValid, serRxLast, netRxValid, netRxLast, peerConnReq, tcpClosed} = '0;
    {paddr, pwdata, serRxData, netRxData} = '0;
    srst       = 1'b1;
    serTxReady = 1'b1;
    netRxPort  = 16'h0BEE;
    digSample  = 16'hA5C3;
    for (int g = 0; g < NCH; g++)
      anaSample[16*g+:16] = 16'h0200 + 16'(g);
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    t_regs;
    t_report(16'h8001, 8'h06);
    t_report(16'h0000, 8'h80);
    t_relay;
    t_hdr;
    t_tcp;
    report_and_stop;
  end
endmodule : ipsf_top_bench
`default_nettype wire
